// ### dv/ehcr_regs_asserts.sv
// Purpose: Concurrent checks on the command and route register bank.
// Assumes: One pclk domain and a zero-wait APB slave.
// Notes:   Bound to every ehcr_regs instance.
`timescale 1ns/1ps
`default_nettype none
module ehcr_regs_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        controller_halted,
  input wire logic        irq_event,
  input wire logic [7:0]  irq_threshold_ctrl,
  input wire logic        light_reset_active,
  input wire logic        usb_irq
);
  import ehcr_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Completing accesses to the command word
  // ----------------------------------------
  sequence seq_cmd_wr;
    psel && penable && pready && pwrite && paddr == EHCR_CMD_OFFS;
  endsequence
  sequence seq_cmd_rd;
    psel && penable && pready && !pwrite && paddr == EHCR_CMD_OFFS;
  endsequence
  chk_setup_answer: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_itc_write: assert property ((seq_cmd_wr ##0 (pstrb[2] && !pwdata[7] &&
    !light_reset_active)) |=> irq_threshold_ctrl == $past(pwdata[23:16]))
    else $error("threshold not taken");
  chk_rd_cmd: assert property (seq_cmd_rd |-> prdata[23:16] == irq_threshold_ctrl &&
    prdata[31:24] == 8'h00)
    else $error("command readback wrong");
  chk_lrst_start: assert property ((seq_cmd_wr ##0 (pstrb[0] && pwdata[7]))
    |=> light_reset_active)
    else $error("light reset not started");
  chk_lrst_len: assert property ($rose(light_reset_active) |->
    light_reset_active[*8] ##1 light_reset_active[*8] ##1 light_reset_active ##1
    !light_reset_active)
    else $error("light reset length wrong");
  chk_lrst_itc: assert property ($fell(light_reset_active) |->
    irq_threshold_ctrl == EHCR_ITC_RESET)
    else $error("threshold not restored");
  chk_route_ro: assert property (psel && penable && pready && pwrite &&
    (paddr == EHCR_ROUTE_LO_OFFS || paddr == EHCR_ROUTE_HI_OFFS) |-> pslverr)
    else $error("route map write accepted");
  chk_irq_pulse: assert property (usb_irq |=> !usb_irq)
    else $error("interrupt longer than one cycle");
endmodule
bind ehcr_regs ehcr_regs_asserts i_ehcr_regs_asserts (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .controller_halted,
  .irq_event, .irq_threshold_ctrl, .light_reset_active, .usb_irq);
`default_nettype wire

// ### dv/testbench.sv
// Purpose: Directed APB tests of the command and route register bank.
// Assumes: Default parameters, two ports, light reset built in.
// Notes:   Software rules are kept by the stimulus itself.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ehcr_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, controller_halted, irq_event;
  logic [7:0]  paddr, irq_threshold_ctrl;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  pstrb;
  logic        pready, pslverr, light_reset_active, usb_irq, e;
  int          num_errors, tests_run, n;
  int          cyc = 0;
  ehcr_regs i_ehcr_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .controller_halted, .irq_event,
    .irq_threshold_ctrl, .light_reset_active, .usb_irq);
  initial pclk = 1'b0;
  always #25 pclk = ~pclk;
  // A hang is cut short well above the expected run length.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  // One APB transfer; the request stands until pready is seen high or 20 access cycles pass.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ready is sampled at each rising edge of the access phase, as the slave sees it.
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      $display("unexpected at %0t: no pready", $time);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    check(q, x);
    check({31'h0, e}, {31'h0, xe});
  endtask
  task automatic wait_irq();
    n = 0;
    while (usb_irq !== 1'b1 && n < 12000) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic pulse_event();
    @(posedge pclk);
    irq_event <= 1'b1;
    @(posedge pclk);
    irq_event <= 1'b0;
  endtask
  task automatic stop_test();
    $display("counts: %0d mismatches in %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, irq_event} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hF;
    controller_halted = 1'b1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(EHCR_CMD_OFFS, 32'h0008_0000, 1'b0);
    check({24'h0, irq_threshold_ctrl}, 32'h08);
    // Every legal threshold code, written only while halted.
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, EHCR_CMD_OFFS, 32'h1 << (16 + i));
      rd(EHCR_CMD_OFFS, 32'h1 << (16 + i), 1'b0);
    end
    $display("test reset and threshold done");
    apb(1'b1, EHCR_ROUTE_CFG_OFFS, 32'h003);
    apb(1'b1, EHCR_ROUTE_CFG_OFFS, 32'h105);
    apb(1'b1, EHCR_ROUTE_CFG_OFFS, 32'hE09);
    rd(EHCR_ROUTE_LO_OFFS, 32'h53, 1'b0);
    rd(EHCR_ROUTE_HI_OFFS, 32'h0, 1'b0);
    apb(1'b1, EHCR_ROUTE_LO_OFFS, 32'hFFFF_FFFF);
    check({31'h0, e}, 32'h1);
    rd(EHCR_ROUTE_LO_OFFS, 32'h53, 1'b0);
    rd(8'h30, 32'h0, 1'b1);
    $display("test route map done");
    apb(1'b1, EHCR_CMD_OFFS, 32'h0002_0080);
    apb(1'b0, EHCR_CMD_OFFS, 32'h0);
    check({31'h0, q[7]}, 32'h1);
    repeat (30) @(posedge pclk);
    rd(EHCR_CMD_OFFS, 32'h0008_0000, 1'b0);
    rd(EHCR_ROUTE_LO_OFFS, 32'h53, 1'b0);
    rd(EHCR_STAT_OFFS, 32'h1000, 1'b0);
    controller_halted <= 1'b0;
    rd(EHCR_STAT_OFFS, 32'h0, 1'b0);
    controller_halted <= 1'b1;
    $display("test light reset done");
    apb(1'b1, EHCR_CMD_OFFS, 32'h0002_0000);
    pulse_event();
    wait_irq();
    check({31'h0, usb_irq}, 32'h1);
    pulse_event();
    wait_irq();
    check({31'h0, n > 2500 && n <= 5100}, 32'h1);
    @(posedge pclk);
    wait_irq();
    check({31'h0, usb_irq}, 32'h0);
    $display("test interrupt pacing done");
    stop_test();
  end
endmodule
`default_nettype wire

// ### inc/ehcr_pkg.sv
// Purpose: Shared constants for the command and port-route register block.
// Assumes: APB with 32-bit data, byte addresses, one word per register.
// Notes:   Every offset, reset value, field position and cycle count is kept here, except the route write fields and status bit 0.
`default_nettype none
package ehcr_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] EHCR_ROUTE_LO_OFFS  = 8'h0C; // Route map, entries 0 to 7.
  localparam logic [7:0] EHCR_ROUTE_HI_OFFS  = 8'h10; // Route map, entries 8 to 14.
  localparam logic [7:0] EHCR_CMD_OFFS       = 8'h20; // Host command register.
  localparam logic [7:0] EHCR_STAT_OFFS      = 8'h24; // Block status word.
  localparam logic [7:0] EHCR_ROUTE_CFG_OFFS = 8'h40; // Route entry write port.

  // ---------------------------------------------------------------------------
  // Field layout of the host command register and status word
  // ---------------------------------------------------------------------------
  localparam int         EHCR_ITC_LSB     = 16;    // Threshold field low bit.
  localparam int         EHCR_ITC_MSB     = 23;    // Threshold field high bit.
  localparam int         EHCR_LRST_BIT    = 7;     // Light controller reset bit.
  localparam int         EHCR_HALT_BIT    = 12;    // Controller halted in status word.
  localparam logic [7:0] EHCR_ITC_RESET   = 8'h08; // Threshold after reset.

  // ---------------------------------------------------------------------------
  // Route map geometry
  // ---------------------------------------------------------------------------
  localparam int         EHCR_N_ENTRIES   = 15;    // Entries in the route map.
  localparam int         EHCR_ENTRY_W     = 4;     // Bits per entry.
  localparam logic [3:0] EHCR_ROUTE_RESET = 4'h0;  // Entry value after reset.

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int EHCR_CLK_HZ      = 20000000;                     // pclk rate.
  localparam int EHCR_UFRAME_NS   = 125000;                       // Microframe length.
  localparam int EHCR_UFRAME_CYC  = EHCR_UFRAME_NS / 50;          // 2500 cycles of 50 ns.
  localparam int EHCR_LRST_CYC    = 16;                           // Light reset timer load; active one cycle longer.

endpackage
`default_nettype wire

// ### src/ehcr_irq_throttle.sv
// Purpose: Holds pending interrupt events until the threshold has elapsed.
// Assumes: Microframe tick is a one-cycle pulse on pclk.
// Notes:   Cleared by the light controller reset.
`timescale 1ns/1ps
`default_nettype none
module ehcr_irq_throttle (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       soft_rst,
  input  wire logic       uframe_tick,
  input  wire logic [7:0] threshold,
  input  wire logic       event_in,
  output logic            irq_ff
);
  import ehcr_pkg::*;

  logic       pend_ff;      // An event waits for delivery.
  logic [7:0] cnt_ff;       // Microframes since the last interrupt.
  logic       nxt_pend;
  logic [7:0] nxt_cnt;
  logic       nxt_irq;

  // ---------------------------------------------------------------------------
  // Throttle
  // ---------------------------------------------------------------------------
  // A new event in the delivery cycle stays pending, so nothing is lost.
  always_comb begin
    nxt_pend = pend_ff;
    nxt_cnt  = cnt_ff;
    nxt_irq  = 1'b0;
    if (uframe_tick && cnt_ff != 8'hFF) begin
      nxt_cnt = cnt_ff + 8'h01;
    end
    if (pend_ff && uframe_tick && (cnt_ff + 8'h01 >= threshold)) begin
      nxt_irq  = 1'b1;
      nxt_pend = 1'b0;
      nxt_cnt  = 8'h00;
    end
    if (event_in) begin
      nxt_pend = 1'b1;
    end
    if (soft_rst) begin
      nxt_pend = 1'b0;
      nxt_cnt  = 8'h00;
      nxt_irq  = 1'b0;
    end
  end

  // Registers only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_ff <= 1'b0;
      cnt_ff  <= 8'h00;
      irq_ff  <= 1'b0;
    end else begin
      pend_ff <= nxt_pend;
      cnt_ff  <= nxt_cnt;
      irq_ff  <= nxt_irq;
    end
  end
endmodule
`default_nettype wire

// ### src/ehcr_regs.sv
// Purpose: APB register bank with the host command register and route map.
// Assumes: Single pclk domain; event and halted inputs come from pclk logic.
// Notes:   Zero-wait-state slave; unmapped addresses read zero with pslverr.
//
// Notes on behaviour
// - Route map optional, read-only, rules flag gated
// - Fifteen route entries of four bits
// - Entry n serves root port n
// - Only implemented ports carry routing values
// - Entry value ranks companion controller
// - Command writes act, not just store
// - Threshold field bits 23:16, resets 08h
// - Threshold codes count microframes, powers two
// - Light reset spares ports and routing
// - Unimplemented light reset reads zero
// - Light reset reads one until done
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module ehcr_regs #(
  parameter int N_PORTS     = 2,     // Implemented root ports.
  parameter bit ROUTE_RULES = 1'b1,  // Routing rules present.
  parameter bit LRST_IMPL   = 1'b1   // Light controller reset built in.
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        controller_halted,
  input  wire logic        irq_event,
  output logic      [7:0]  irq_threshold_ctrl,
  output logic             light_reset_active,
  output logic             usb_irq
);
  import ehcr_pkg::*;

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic [31:0] prdata_ff,  nxt_prdata;   // Registered read data.
  logic        pslverr_ff, nxt_pslverr;  // Registered error answer.
  logic        pready_ff,  nxt_pready;   // Registered ready.
  logic [7:0]  itc_ff,     nxt_itc;      // Threshold field.
  logic        lrst_ff,    nxt_lrst;     // Light reset in progress.
  logic [4:0]  lcnt_ff,    nxt_lcnt;     // Light reset timer.
  logic [11:0] ufc_ff,     nxt_ufc;      // Microframe cycle counter.
  logic        tick;                     // Microframe boundary.
  logic        acc;                      // Access phase of a transfer.
  logic        wr;                       // Write taking effect.
  logic        rt_wr;                    // Route entry write.
  logic        rt_rd_hi;                 // Selects upper route word.
  logic [31:0] rt_word;                  // Route word from storage.
  logic        irq_w;                    // Throttled interrupt.
  logic        sel_rt_ff,  nxt_sel_rt;   // Read answer comes from route store.

  // Byte lane merge used by the command register.
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  assign acc      = psel && penable;
  assign wr       = acc && pwrite;
  assign rt_wr    = wr && (paddr == EHCR_ROUTE_CFG_OFFS) && ROUTE_RULES;
  assign rt_rd_hi = (paddr == EHCR_ROUTE_HI_OFFS);
  assign tick     = (ufc_ff == 12'(EHCR_UFRAME_CYC - 1));

  // ---------------------------------------------------------------------------
  // Route storage
  // ---------------------------------------------------------------------------
  // The light reset does not touch this store: routing survives it.
  ehcr_route_mem #(
    .N_PORTS (N_PORTS)
  ) u_route (
    .pclk       (pclk),
    .presetn    (presetn),
    .wr_en      (rt_wr),
    .wr_idx     (pwdata[11:8]),
    .wr_val     (pwdata[3:0]),
    .rd_hi      (rt_rd_hi),
    .rd_word_ff (rt_word)
  );

  // ---------------------------------------------------------------------------
  // Interrupt pacing
  // ---------------------------------------------------------------------------
  ehcr_irq_throttle u_thr (
    .pclk        (pclk),
    .presetn     (presetn),
    .soft_rst    (lrst_ff),
    .uframe_tick (tick),
    .threshold   (itc_ff),
    .event_in    (irq_event),
    .irq_ff      (irq_w)
  );

  // ---------------------------------------------------------------------------
  // Command register and light reset
  // ---------------------------------------------------------------------------
  // A command write acts at once: setting the light reset bit starts the timer.
  always_comb begin
    logic [31:0] m;
    m        = lane_merge({8'h00, itc_ff, 8'h00, 8'h00}, pwdata, pstrb);
    nxt_itc  = itc_ff;
    nxt_lrst = lrst_ff;
    nxt_lcnt = lcnt_ff;
    if (wr && paddr == EHCR_CMD_OFFS) begin
      // Threshold taken as written; software keeps it legal and halted-only.
      nxt_itc = m[EHCR_ITC_MSB:EHCR_ITC_LSB];
      if (LRST_IMPL && m[EHCR_LRST_BIT] && !lrst_ff) begin
        nxt_lrst = 1'b1;
        nxt_lcnt = 5'(EHCR_LRST_CYC);
      end
    end
    if (lrst_ff) begin
      // Controller logic returns to defaults; ports and routing are kept.
      nxt_itc = EHCR_ITC_RESET;
      if (lcnt_ff == 5'h00) begin
        nxt_lrst = 1'b0;
      end else begin
        nxt_lcnt = lcnt_ff - 5'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      itc_ff  <= EHCR_ITC_RESET;
      lrst_ff <= 1'b0;
      lcnt_ff <= 5'h00;
    end else begin
      itc_ff  <= nxt_itc;
      lrst_ff <= nxt_lrst;
      lcnt_ff <= nxt_lcnt;
    end
  end

  // ---------------------------------------------------------------------------
  // Microframe timebase
  // ---------------------------------------------------------------------------
  // Restarted by the light reset so the pacing starts clean.
  always_comb begin
    nxt_ufc = tick ? 12'h000 : ufc_ff + 12'h001;
    if (lrst_ff) begin
      nxt_ufc = 12'h000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ufc_ff <= 12'h000;
    end else begin
      ufc_ff <= nxt_ufc;
    end
  end

  // ---------------------------------------------------------------------------
  // APB answer
  // ---------------------------------------------------------------------------
  // Read data are registered in the setup cycle, so pready goes high in the
  // first access cycle: every transfer takes exactly two cycles.
  always_comb begin
    nxt_prdata  = 32'h0;
    nxt_pslverr = 1'b0;
    nxt_sel_rt  = 1'b0;
    nxt_pready  = psel && !penable;
    if (psel && !penable) begin
      unique case (paddr)
        EHCR_ROUTE_LO_OFFS, EHCR_ROUTE_HI_OFFS: begin
          // Read-only; writes ignored. Zero when routing rules are absent.
          nxt_sel_rt  = ROUTE_RULES;
          nxt_pslverr = pwrite;
        end
        EHCR_CMD_OFFS: begin
          // Reserved bits read zero; light reset bit reads zero if absent.
          nxt_prdata[EHCR_ITC_MSB:EHCR_ITC_LSB] = itc_ff;
          nxt_prdata[EHCR_LRST_BIT] = LRST_IMPL && lrst_ff;
        end
        EHCR_STAT_OFFS: begin
          nxt_prdata[EHCR_HALT_BIT] = controller_halted;
          nxt_prdata[0]             = lrst_ff;
        end
        EHCR_ROUTE_CFG_OFFS: begin
          nxt_pslverr = !pwrite;
        end
        default: begin
          nxt_pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0;
      pslverr_ff <= 1'b0;
      pready_ff  <= 1'b0;
      sel_rt_ff  <= 1'b0;
    end else begin
      prdata_ff  <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
      pready_ff  <= nxt_pready;
      sel_rt_ff  <= nxt_sel_rt;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  // Route word and prdata_ff are both registers; the select only picks one.
  assign prdata             = sel_rt_ff ? rt_word : prdata_ff;
  assign pready             = pready_ff;
  assign pslverr            = pslverr_ff;
  assign irq_threshold_ctrl = itc_ff;
  assign light_reset_active = lrst_ff;
  assign usb_irq            = irq_w;
endmodule
`default_nettype wire

// ### src/ehcr_route_mem.sv
// Purpose: Storage for the fifteen route entries with a registered read word.
// Assumes: One writer port; reads return a whole 32-bit half of the map.
// Notes:   Entries above the port count read as zero.
`timescale 1ns/1ps
`default_nettype none
module ehcr_route_mem #(
  parameter int N_PORTS = 2
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        wr_en,
  input  wire logic [3:0]  wr_idx,
  input  wire logic [3:0]  wr_val,
  input  wire logic        rd_hi,
  output logic      [31:0] rd_word_ff
);
  import ehcr_pkg::*;

  logic [3:0]  ent_ff  [EHCR_N_ENTRIES];  // Stored entries.
  logic [3:0]  nxt_ent [EHCR_N_ENTRIES];  // Next entry values.
  logic [31:0] nxt_rd_word;               // Next read word.
  logic [63:0] flat;                      // Flattened map, entry 0 lowest.

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  // Only implemented ports accept a value, so unused entries stay zero.
  always_comb begin
    flat = 64'h0;
    for (int i = 0; i < EHCR_N_ENTRIES; i++) begin
      nxt_ent[i] = ent_ff[i];
      if (wr_en && (32'(wr_idx) == i) && (i < N_PORTS)) begin
        nxt_ent[i] = wr_val;
      end
      flat[i*EHCR_ENTRY_W +: EHCR_ENTRY_W] = ent_ff[i];
    end
    nxt_rd_word = rd_hi ? flat[63:32] : flat[31:0];
  end

  // Registers only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < EHCR_N_ENTRIES; i++) begin
        ent_ff[i] <= EHCR_ROUTE_RESET;
      end
      rd_word_ff <= 32'h0;
    end else begin
      ent_ff     <= nxt_ent;
      rd_word_ff <= nxt_rd_word;
    end
  end
endmodule
`default_nettype wire
